// ===== design/mia_pkg.sv
// Constants and carrier types for the module I/O and node address block.
// Assumes a single 20 MHz core clock and a plain register port.
package mia_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Straps and pad short must be stable this long before they are sampled
  localparam int unsigned STRAP_SETTLE_NS = 10_000;
  localparam int unsigned SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEFAULT_BAUD = 9_600;
  localparam int unsigned MAX_BAUD = 1_000_000;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / DEFAULT_BAUD);
  // Least divider: a faster rate than the transceiver limit is never produced
  localparam logic [15:0] BAUD_DIV_MIN = 16'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NV_ADDR = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_AIN = 8'h10;
  localparam logic [7:0] OFS_INPUTS = 8'h14;

  // CTRL fields
  localparam int unsigned CTRL_LIMIT_L_EN = 0;
  localparam int unsigned CTRL_LIMIT_R_EN = 1;
  localparam int unsigned CTRL_DRIVER_ONLY = 2;
  localparam int unsigned CTRL_AIN_DIGITAL = 3;
  localparam int unsigned CTRL_GENERAL_DIGITAL_OUTPUT = 4;
  localparam int unsigned CTRL_CAN_REQ = 5;
  localparam int unsigned CTRL_NODE_PROTO = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // NV_ADDR fields
  localparam int unsigned NVA_MOD_LSB = 0;
  localparam int unsigned NVA_REPLY_LSB = 8;
  localparam int unsigned NVA_NODE_LSB = 16;

  // Address defaults
  localparam logic [7:0] MOD_ADDR_DEFAULT = 8'h01;
  localparam logic [7:0] REPLY_ADDR_DEFAULT = 8'h02;
  localparam logic [6:0] NODE_ID_DEFAULT = 7'h01;
  localparam logic [7:0] STRAP_REPLY_ADDR = 8'hff;

  localparam int unsigned ADC_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Persistent settings image
  typedef struct packed {
    logic [7:0] module_addr;
    logic [7:0] reply_addr;
    logic [6:0] node_id;
    logic [15:0] baud_div;
  } mia_nv_t;

  localparam mia_nv_t NV_DEFAULT = '{
    module_addr: MOD_ADDR_DEFAULT,
    reply_addr: REPLY_ADDR_DEFAULT,
    node_id: NODE_ID_DEFAULT,
    baud_div: BAUD_DIV_DEFAULT
  };

  // Addresses in force
  typedef struct packed {
    logic [7:0] module_addr;
    logic [7:0] reply_addr;
    logic [6:0] node_id;
    logic from_strap;
  } mia_addr_t;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_SAMPLE,
    ST_RUN
  } mia_state_t;

endpackage : mia_pkg

// ===== design/mia_top.sv
// Module I/O and node address logic of a single-axis stepper module.
// Assumes all pins are asynchronous to core_clk, the ramp generator and ADC
// run on core_clk, and a nonvolatile store presents its image at reset.
//
// Operation
// - With all four address straps low, the stored node address and node id are used.
// - With any strap high, the command-protocol module address is the strap value 1 to 15.
// - While the address comes from the straps, the reply address is 255 on every link.
// - In node-id protocol mode with any strap high, the node id is the strap value 1 to 15.
// - With left limit enabled, negative-direction steps are blocked while the left input is active.
// - With right limit enabled, positive-direction steps are blocked while the right input is active.
// - The analog input reads as a 12-bit code from 0 to 4095.
// - The analog input may instead be read as a plain digital level.
// - Shorted debug pads at power-up restore all persistent settings to factory defaults.
// - After a factory restore the serial link runs at 9600 bit/s, never above 1 Mbit/s.
// - The CAN interface is disabled whenever USB is present.
// - In driver-only mode external step and direction inputs move the motor.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mia_top
  import mia_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic bus_ready,
  // Address straps and factory restore pads
  input wire logic node_strap_bit_zero,
  input wire logic node_strap_bit_one,
  input wire logic node_strap_bit_two,
  input wire logic node_strap_bit_three,
  input wire logic debug_pad_data,
  // Persistent settings store
  input wire mia_nv_t nv_image_in,
  output mia_nv_t nv_image_out,
  output logic nv_commit,
  // Addresses in force
  output mia_addr_t addr_active,
  // General inputs and output
  input wire logic analog_general_input,
  input wire logic [ADC_W-1:0] adc_code,
  input wire logic adc_valid,
  input wire logic general_digital_input_a,
  input wire logic general_digital_input_b,
  output logic general_digital_output,
  input wire logic quadrature_channel_a,
  input wire logic quadrature_channel_b,
  input wire logic quadrature_index,
  // Limit switches
  input wire logic limit_left_in,
  input wire logic limit_right_in,
  // Motion sources and driver outputs
  input wire logic ramp_step,
  input wire logic ramp_dir,
  input wire logic ext_step_in,
  input wire logic ext_dir_in,
  output logic drv_step,
  output logic drv_dir,
  // Communication control
  input wire logic usb_present,
  output logic can_enable,
  output logic serial_bit_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one feeds stage two only
  localparam int unsigned NSYNC = 15;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic step_prev_r;

  assign pins_raw = {ext_dir_in, ext_step_in, usb_present, limit_right_in, limit_left_in,
                     quadrature_index, quadrature_channel_b, quadrature_channel_a,
                     general_digital_input_b, general_digital_input_a,
                     analog_general_input, debug_pad_data,
                     node_strap_bit_three, node_strap_bit_two, node_strap_bit_one};

  // Strap bit zero is synchronised on its own to keep the bit order obvious
  logic strap0_s1_r;
  logic strap0_s2_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      strap0_s1_r <= 1'b0;
      strap0_s2_r <= 1'b0;
      step_prev_r <= 1'b0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      strap0_s1_r <= node_strap_bit_zero;
      strap0_s2_r <= strap0_s1_r;
      step_prev_r <= sync2_r[13];
    end
  end

  logic [3:0] strap_s;
  logic pad_short_s;
  logic ain_dig_s;
  logic usb_s;
  logic lim_l_s;
  logic lim_r_s;
  logic ext_step_s;
  logic ext_dir_s;

  assign strap_s = {sync2_r[2:0], strap0_s2_r};
  assign pad_short_s = sync2_r[3];
  assign ain_dig_s = sync2_r[4];
  assign lim_l_s = sync2_r[10];
  assign lim_r_s = sync2_r[11];
  assign usb_s = sync2_r[12];
  assign ext_step_s = sync2_r[13];
  assign ext_dir_s = sync2_r[14];

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequence: settle, sample once, then serve the bus
  mia_state_t state_r, state_nxt;
  logic [15:0] settle_cnt_r, settle_cnt_nxt;
  logic [3:0] strap_r, strap_nxt;
  logic factory_r, factory_nxt;

  always_comb begin
    state_nxt = state_r;
    settle_cnt_nxt = settle_cnt_r;
    strap_nxt = strap_r;
    factory_nxt = factory_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_cnt_r == 16'(SETTLE_CYC - 1)) begin
          state_nxt = ST_SAMPLE;
        end else begin
          settle_cnt_nxt = settle_cnt_r + 16'h0001;
        end
      end
      ST_SAMPLE: begin
        strap_nxt = strap_s;
        factory_nxt = pad_short_s;
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_SETTLE;
      settle_cnt_r <= 16'h0000;
      strap_r <= 4'h0;
      factory_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      strap_r <= strap_nxt;
      factory_r <= factory_nxt;
    end
  end

  logic sample_now;
  logic run;
  assign sample_now = (state_r == ST_SAMPLE);
  assign run = (state_r == ST_RUN);
  assign bus_ready = run;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and persistent settings
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  mia_nv_t nv_r, nv_nxt;
  logic commit_r, commit_nxt;
  logic wr_go;

  // Divider never goes below the 1 Mbit/s floor
  function automatic logic [15:0] clamp_div(input logic [15:0] div);
    clamp_div = (div < BAUD_DIV_MIN) ? BAUD_DIV_MIN : div;
  endfunction : clamp_div

  // Strap value replaces the stored one unless all straps are low
  function automatic logic [7:0] pick_addr(input logic [3:0] strap, input logic [7:0] stored);
    pick_addr = (strap == 4'h0) ? stored : {4'h0, strap};
  endfunction : pick_addr

  assign wr_go = reg_wr && run;

  always_comb begin
    ctrl_nxt = ctrl_r;
    nv_nxt = nv_r;
    commit_nxt = 1'b0;
    if (sample_now) begin
      if (pad_short_s) begin
        nv_nxt = NV_DEFAULT;
        commit_nxt = 1'b1;
      end else begin
        nv_nxt = nv_image_in;
        nv_nxt.baud_div = clamp_div(nv_image_in.baud_div);
      end
    end else if (wr_go) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_nxt = reg_wdata[CTRL_W-1:0];
      end else if (reg_addr == OFS_NV_ADDR) begin
        nv_nxt.module_addr = reg_wdata[NVA_MOD_LSB +: 8];
        nv_nxt.reply_addr = reg_wdata[NVA_REPLY_LSB +: 8];
        nv_nxt.node_id = reg_wdata[NVA_NODE_LSB +: 7];
        commit_nxt = 1'b1;
      end else if (reg_addr == OFS_BAUD) begin
        nv_nxt.baud_div = clamp_div(reg_wdata[15:0]);
        commit_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
      nv_r <= NV_DEFAULT;
      commit_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      nv_r <= nv_nxt;
      commit_r <= commit_nxt;
    end
  end

  assign nv_image_out = nv_r;
  assign nv_commit = commit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Addresses in force
  mia_addr_t addr_r, addr_nxt;

  always_comb begin
    addr_nxt.from_strap = (strap_r != 4'h0);
    addr_nxt.module_addr = pick_addr(strap_r, nv_r.module_addr);
    addr_nxt.reply_addr = (strap_r != 4'h0) ? STRAP_REPLY_ADDR : nv_r.reply_addr;
    // Node id follows the straps only under the node-id protocol
    if (ctrl_r[CTRL_NODE_PROTO] && (strap_r != 4'h0)) begin
      addr_nxt.node_id = {3'h0, strap_r};
    end else begin
      addr_nxt.node_id = nv_r.node_id;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= '0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  assign addr_active = addr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Analog input capture
  logic [ADC_W-1:0] adc_r, adc_nxt;

  always_comb begin
    adc_nxt = adc_r;
    if (adc_valid) begin
      adc_nxt = adc_code;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_r <= '0;
    end else begin
      adc_r <= adc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step gating against limit switches
  logic step_src;
  logic dir_src;
  logic block_step;
  logic step_q_r, step_q_nxt;
  logic dir_q_r, dir_q_nxt;

  always_comb begin
    if (ctrl_r[CTRL_DRIVER_ONLY]) begin
      step_src = ext_step_s && !step_prev_r;
      dir_src = ext_dir_s;
    end else begin
      step_src = ramp_step;
      dir_src = ramp_dir;
    end
    // Direction high counts up; low counts down
    block_step = (!dir_src && ctrl_r[CTRL_LIMIT_L_EN] && lim_l_s)
              || (dir_src && ctrl_r[CTRL_LIMIT_R_EN] && lim_r_s);
    step_q_nxt = step_src && !block_step && run;
    dir_q_nxt = dir_src;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_q_r <= 1'b0;
      dir_q_r <= 1'b0;
    end else begin
      step_q_r <= step_q_nxt;
      dir_q_r <= dir_q_nxt;
    end
  end

  assign drv_step = step_q_r;
  assign drv_dir = dir_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bit-rate enable and CAN gating
  logic [15:0] baud_cnt_r, baud_cnt_nxt;
  logic tick_r, tick_nxt;
  logic can_r, can_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    baud_cnt_nxt = baud_cnt_r + 16'h0001;
    if (baud_cnt_r >= nv_r.baud_div - 16'h0001) begin
      baud_cnt_nxt = 16'h0000;
      tick_nxt = run;
    end
    can_nxt = ctrl_r[CTRL_CAN_REQ] && !usb_s && run;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
      can_r <= 1'b0;
    end else begin
      baud_cnt_r <= baud_cnt_nxt;
      tick_r <= tick_nxt;
      can_r <= can_nxt;
    end
  end

  assign serial_bit_tick = tick_r;
  assign can_enable = can_r;
  assign general_digital_output = ctrl_r[CTRL_GENERAL_DIGITAL_OUTPUT];

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data in the cycle after the strobe
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd && run) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_nxt = {25'h000_0000, ctrl_r};
      end else if (reg_addr == OFS_NV_ADDR) begin
        rdata_nxt = {9'h000, nv_r.node_id, nv_r.reply_addr, nv_r.module_addr};
      end else if (reg_addr == OFS_BAUD) begin
        rdata_nxt = {16'h0000, nv_r.baud_div};
      end else if (reg_addr == OFS_STATUS) begin
        rdata_nxt = {4'h0, usb_s, can_r, factory_r, addr_r.from_strap,
                     1'b0, addr_r.node_id, addr_r.reply_addr, addr_r.module_addr};
      end else if (reg_addr == OFS_AIN) begin
        if (ctrl_r[CTRL_AIN_DIGITAL]) begin
          rdata_nxt = {31'h0000_0000, ain_dig_s};
        end else begin
          rdata_nxt = {20'h0_0000, adc_r};
        end
      end else if (reg_addr == OFS_INPUTS) begin
        rdata_nxt = {21'h00_0000, ext_dir_s, ext_step_s, lim_r_s, lim_l_s,
                     sync2_r[9:5], ain_dig_s, strap_s != 4'h0};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : mia_top

// ===== tb/mia_io_properties.sv
// Port-level checks for mia_top.
// Assumes one clock core_clk and the async active-high sys_rst.
`timescale 1ns/1ps
module mia_io_properties
  import mia_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic bus_ready,
  // Pins and results
  input wire logic debug_pad_data,
  input wire mia_nv_t nv_image_out,
  input wire mia_addr_t addr_active,
  input wire logic limit_left_in,
  input wire logic limit_right_in,
  input wire logic ext_step_in,
  input wire logic drv_step,
  input wire logic drv_dir,
  input wire logic usb_present,
  input wire logic can_enable
);
  logic [2:0] ctrl_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Copy of the enables, so the gating checks know what software asked for
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= 3'h0;
    end else if (reg_wr && bus_ready && reg_addr == OFS_CTRL) begin
      ctrl_r <= reg_wdata[2:0];
    end
  end

  // Four samples cover the two-stage synchroniser on the limit pins
  sequence s_left_held;
    limit_left_in[*4] ##0 ctrl_r[CTRL_LIMIT_L_EN];
  endsequence
  sequence s_right_held;
    limit_right_in[*4] ##0 ctrl_r[CTRL_LIMIT_R_EN];
  endsequence
  sequence s_pad_start;
    debug_pad_data[*8] ##0 $rose(bus_ready);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_strap_reply: assert property (addr_active.from_strap |->
    addr_active.reply_addr == STRAP_REPLY_ADDR) else $error("strap reply address wrong");
  a_strap_range: assert property (addr_active.from_strap |->
    addr_active.module_addr inside {[8'h01:8'h0f]}) else $error("strap address out of range");
  a_left_block: assert property (s_left_held |=> !(drv_step && !drv_dir))
    else $error("negative step passed left limit");
  a_right_block: assert property (s_right_held |=> !(drv_step && drv_dir))
    else $error("positive step passed right limit");
  a_baud_floor: assert property (nv_image_out.baud_div >= BAUD_DIV_MIN)
    else $error("divider below rate limit");
  a_usb_can: assert property (usb_present[*5] |-> !can_enable)
    else $error("can enabled with usb present");
  a_early_refused: assert property (!bus_ready && reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read served before sampling");
  a_ready_hold: assert property (bus_ready |=> bus_ready)
    else $error("ready dropped without reset");
  a_ext_step: assert property (ctrl_r == 3'h4 && $rose(ext_step_in) |-> ##[2:4] drv_step)
    else $error("external step not passed on");
  a_restore_default: assert property (s_pad_start |-> nv_image_out == NV_DEFAULT)
    else $error("factory image not restored");
endmodule : mia_io_properties

// ===== tb/mia_nv_store.sv
// Model of the nonvolatile settings store beside mia_top.
// Assumes commits come as one-cycle pulses on core_clk.
`timescale 1ns/1ps
module mia_nv_store
  import mia_pkg::*;
#(
  parameter mia_nv_t INIT = NV_DEFAULT
)
(
  // Clock
  input wire logic core_clk,
  // Store port
  input wire mia_nv_t nv_image_out,
  input wire logic nv_commit,
  output mia_nv_t nv_image_in
);
  mia_nv_t mem_r = INIT;
  // Image only moves on a commit, so it is stable whenever it is sampled
  always_ff @(posedge core_clk) begin
    if (nv_commit) begin
      mem_r <= nv_image_out;
    end
  end
  assign nv_image_in = mem_r;
endmodule : mia_nv_store

// ===== tb/mia_top_tb_top.sv
// Bench for mia_top: register tasks, pin stimulus, settings store model.
// Assumes mia_pkg, mia_nv_store and mia_io_properties are compiled first.
`timescale 1ns/1ps
module mia_top_tb_top
  import mia_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic bus_ready, nv_commit, gp_out, drv_step, drv_dir, can_en, tick;
  logic [3:0] strap = 4'h0;
  logic pad = 1'b0;
  logic ain_lvl = 1'b0;
  logic adc_valid = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic lim_l = 1'b0;
  logic lim_r = 1'b0;
  logic ramp_step = 1'b0;
  logic ramp_dir = 1'b0;
  logic ext_step = 1'b0;
  logic ext_dir = 1'b1;
  logic usb = 1'b0;
  mia_nv_t nv_in, nv_out;
  mia_addr_t addr_act;
  int error_cnt = 0;
  int checks = 0;

  always #25 core_clk = ~core_clk;

  mia_nv_store #(.INIT('{8'h21, 8'h22, 7'h23, 16'h0064})) i_store (
    .core_clk(core_clk), .nv_image_out(nv_out), .nv_commit(nv_commit), .nv_image_in(nv_in));

  mia_top i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ready(bus_ready),
    .node_strap_bit_zero(strap[0]), .node_strap_bit_one(strap[1]),
    .node_strap_bit_two(strap[2]), .node_strap_bit_three(strap[3]),
    .debug_pad_data(pad), .nv_image_in(nv_in), .nv_image_out(nv_out), .nv_commit(nv_commit),
    .addr_active(addr_act), .analog_general_input(ain_lvl), .adc_code(adc_code),
    .adc_valid(adc_valid), .general_digital_input_a(1'b0), .general_digital_input_b(1'b1),
    .general_digital_output(gp_out), .quadrature_channel_a(1'b0),
    .quadrature_channel_b(1'b1), .quadrature_index(1'b0), .limit_left_in(lim_l),
    .limit_right_in(lim_r), .ramp_step(ramp_step), .ramp_dir(ramp_dir),
    .ext_step_in(ext_step), .ext_dir_in(ext_dir), .drv_step(drv_step), .drv_dir(drv_dir),
    .usb_present(usb), .can_enable(can_en), .serial_bit_tick(tick));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [38:0] got, input logic [38:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic step(input logic d, output logic s);
    @(posedge core_clk);
    ramp_step <= 1'b1;
    ramp_dir <= d;
    @(posedge core_clk);
    ramp_step <= 1'b0;
    #1 s = drv_step;
  endtask : step

  // Straps are held through reset so they are settled at the sample point
  task automatic boot(input logic [3:0] st, input logic p);
    logic [31:0] v;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    strap <= st;
    pad <= p;
    ext_step <= 1'b0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_NV_ADDR, v);
    check("early read", v, 32'h0000_0000);
    for (int i = 0; i < 300 && bus_ready !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    #1;
    if (bus_ready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic s;
    logic [7:0] n;
    boot(4'h0, 1'b0);
    check("module addr", addr_act.module_addr, 8'h21);
    check("reply addr", addr_act.reply_addr, 8'h22);
    check("strap flag", addr_act.from_strap, 1'b0);
    rd(OFS_NV_ADDR, v);
    check("nv addr reg", v, 32'h0023_2221);
    wr(OFS_BAUD, 32'h0000_0005);
    check("baud floor", nv_out.baud_div, 16'h0014);
    n = 8'h00;
    repeat (100) begin
      @(posedge core_clk);
      #1 n = n + {7'h00, tick};
    end
    check("tick count", n, 8'h05);
    @(posedge core_clk);
    lim_l <= 1'b1;
    lim_r <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 0) begin
        wr(OFS_CTRL, 32'(k / 2 + 1));
      end
      step(k[0], s);
      check("limit gate", s, (k == 1 || k == 2));
    end
    @(posedge core_clk);
    lim_l <= 1'b0;
    lim_r <= 1'b0;
    adc_code <= 12'hfff;
    adc_valid <= 1'b1;
    @(posedge core_clk);
    adc_valid <= 1'b0;
    rd(OFS_AIN, v);
    check("ain code", v, 32'h0000_0fff);
    @(posedge core_clk);
    ain_lvl <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0018);
    rd(OFS_AIN, v);
    check("ain level", v, 32'h0000_0001);
    check("output pin", gp_out, 1'b1);
    wr(OFS_CTRL, 32'h0000_0020);
    check("output off", gp_out, 1'b0);
    repeat (4) @(posedge core_clk);
    #1 check("can on", can_en, 1'b1);
    @(posedge core_clk);
    usb <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 check("can off", can_en, 1'b0);
    @(posedge core_clk);
    usb <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0004);
    @(posedge core_clk);
    ext_step <= 1'b1;
    ext_dir <= 1'b0;
    s = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      #1 s = s | drv_step;
    end
    check("ext step", s, 1'b1);
    check("ext dir", drv_dir, 1'b0);
    boot(4'b1010, 1'b0);
    check("strap addr", addr_act.module_addr, 8'h0a);
    check("strap reply", addr_act.reply_addr, 8'hff);
    check("stored node", addr_act.node_id, 7'h23);
    rd(OFS_STATUS, v);
    check("status strap", v, 32'h0123_ff0a);
    wr(OFS_CTRL, 32'h0000_0040);
    @(posedge core_clk);
    #1 check("strap node", addr_act.node_id, 7'h0a);
    boot(4'h0, 1'b1);
    check("restored image", nv_out, NV_DEFAULT);
    check("default divider", nv_out.baud_div, 16'h0823);
    check("stored default", nv_in, NV_DEFAULT);
    rd(OFS_STATUS, v);
    check("status restore", v, 32'h0201_0201);
    @(posedge core_clk);
    pad <= 1'b0;
    report_and_stop();
  end
endmodule : mia_top_tb_top

bind mia_top mia_io_properties i_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ready(bus_ready),
  .debug_pad_data(debug_pad_data), .nv_image_out(nv_image_out), .addr_active(addr_active),
  .limit_left_in(limit_left_in), .limit_right_in(limit_right_in), .ext_step_in(ext_step_in),
  .drv_step(drv_step), .drv_dir(drv_dir), .usb_present(usb_present), .can_enable(can_enable));
